// ==== verilog/aclc_link_ctrl.sv ====
// Controller end of a thirteen-slot serial audio link with a bus register file.
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Frames multiplex samples and codec register traffic.
// - Thirteen slots each way per frame: the tag slot and twelve data slots.
// - Up to two codecs, one input line each.
// - Bit clock edges time all link data.
// - Input line rising while asleep means wake.
// - Pulls enabled only while link is off.
// - Drive serial out while link is on.
// - Assume a codec exists when link enabled.
// - Multi-channel output waits for the slot 3 request and each surround/centre slot request; slot 4's is not checked.
// - Controller drives the active-low link reset.
// - Board codec enable low means on-board primary.
module aclc_link_ctrl
  import aclc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register bus slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  // Serial link pins.
  input  wire logic        bit_clk,
  input  wire logic        serial_in_first,
  input  wire logic        serial_in_second,
  output logic             frame_sync,
  output logic             ctrl_serial_out,
  output logic             ctrl_serial_out_oe,
  output logic             link_reset_n,
  output logic             pull_enable,
  // Board strap.
  input  wire logic        board_codec_enable_n
);

  // ==========================================================================
  // Declarations.
  typedef enum {ST_OFF, ST_RESET, ST_WAIT, ST_RUN} aclc_state_type;

  aclc_state_type state_reg;      // Link sequencer state.
  aclc_ctrl_type  ctrl_reg;       // Software control fields.
  logic [3:0]     sts_reg;        // Sticky events.
  logic [3:0]     mask_reg;       // Interrupt mask.
  logic [3:0]     ev;             // Events of this cycle.
  logic [23:0]    cmd_reg;        // Read flag, index, data.
  logic           cmd_pend_reg;   // Command waits for a frame.
  logic [31:0]    front_reg;      // Queued samples.
  logic [31:0]    surr_reg;
  logic [31:0]    clfe_reg;
  logic [2:0]     qv_reg;         // Valid flags: front, surround, centre.
  logic [22:0]    cstat_reg;      // Index and data of the last reply.
  logic [31:0]    pcm_in_reg;     // Last received left/right sample.
  logic [3:0]     pin_q;          // Synchronised pins.
  logic           bclk_d_reg;     // Previous synchronised bit clock.
  logic           bclk_rise;
  logic           bclk_fall;
  logic [1:0]     sdin_d_reg;     // Previous synchronised data inputs.
  logic           active;         // Frame counter may run.
  logic [3:0]     slot_reg;       // Slot in progress.
  logic [4:0]     sbit_reg;       // Bits left in the slot.
  logic [3:0]     slot_next;
  logic [19:0]    sh_reg;         // Outgoing slot shifter.
  logic [19:0]    word;           // Word loaded at a slot start.
  logic [23:0]    tx_cmd_reg;     // Frame snapshot of the command.
  logic [31:0]    tx_front_reg;   // Frame snapshots of the samples.
  logic [31:0]    tx_surr_reg;
  logic [31:0]    tx_clfe_reg;
  logic           req_ok;         // Every needed slot except slot 4 is requested.
  logic           go;             // Samples go out this frame.
  logic           frame_start;
  aclc_frame_type rx1;            // Frames from each codec.
  aclc_frame_type rx2;
  logic           rx1_done;
  logic           rx2_done;
  logic           smp;
  logic           rd_ack;         // Bus handshake completes now.
  logic           wr_ack;
  logic [31:0]    rd_mux;
  logic [31:0]    wm;             // Merged write word.

  // ==========================================================================
  // Pin synchronisers: bit clock, both data inputs and the board strap.
  aclc_pin_sync #(.W(4)) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({board_codec_enable_n, serial_in_second, serial_in_first, bit_clk}),
    .q     (pin_q)
  );

  // Edge finders run on the second synchroniser stage only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_d_reg <= 1'b0;
      sdin_d_reg <= 2'b00;
    end else begin
      bclk_d_reg <= pin_q[0];
      sdin_d_reg <= pin_q[2:1];
    end
  end

  assign bclk_rise = pin_q[0] & ~bclk_d_reg;
  assign bclk_fall = ~pin_q[0] & bclk_d_reg;

  // ==========================================================================
  // Link sequencer. No codec presence check: an enabled link is trusted.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_RESET;
    end else begin
      case (state_reg)
        ST_OFF: begin
          if (!ctrl_reg.link_off) begin
            state_reg <= ST_RESET;
          end
        end
        ST_RESET: begin
          if (ctrl_reg.link_off) begin
            state_reg <= ST_OFF;
          end else if (ctrl_reg.link_run) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT, ST_RUN: begin
          if (ctrl_reg.link_off || !ctrl_reg.link_run) begin
            state_reg <= ST_RESET;
          end else if (bclk_rise) begin
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_RESET;
      endcase
    end
  end

  assign active = (state_reg == ST_WAIT) || (state_reg == ST_RUN);

  // Pin drivers are registered: link reset from the sequencer state, pull and drive from link_off.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_reset_n       <= 1'b0;
      pull_enable        <= 1'b0;
      ctrl_serial_out_oe <= 1'b1;
    end else begin
      link_reset_n       <= active;
      pull_enable        <= ctrl_reg.link_off;
      ctrl_serial_out_oe <= !ctrl_reg.link_off;
    end
  end

  // ==========================================================================
  // Frame counter: slot 0 is 16 bits, slots 1 to 12 are 20 bits.
  assign slot_next   = (slot_reg == SLOT_FINAL) ? 4'h0 : slot_reg + 4'h1;
  assign frame_start = active && bclk_rise && (sbit_reg == 5'h00) &&
                       (slot_next == 4'h0);

  // Slot requests are active low; which ones count depends on channel mode.
  always_comb begin
    req_ok = !rx1.s1[REQ_S3];
    if (ctrl_reg.chan == CH_FOUR || ctrl_reg.chan == CH_SIX) begin
      req_ok = req_ok && !rx2.s1[REQ_S7] && !rx2.s1[REQ_S8];
    end
    if (ctrl_reg.chan == CH_SIX) begin
      req_ok = req_ok && !rx2.s1[REQ_S6] && !rx2.s1[REQ_S9];
    end
  end

  // All needed sample queues must hold data as well; nothing goes early.
  always_comb begin
    go = req_ok && qv_reg[0];
    if (ctrl_reg.chan == CH_FOUR || ctrl_reg.chan == CH_SIX) begin
      go = go && qv_reg[1];
    end
    if (ctrl_reg.chan == CH_SIX) begin
      go = go && qv_reg[2];
    end
  end

  // Word for the slot about to start; tag bits mark the valid slots.
  always_comb begin
    case (slot_next)
      4'h0: word = {1'b1, cmd_pend_reg, cmd_pend_reg, go, go, 1'b0,
                    go && ctrl_reg.chan == CH_SIX,
                    go && ctrl_reg.chan != CH_TWO,
                    go && ctrl_reg.chan != CH_TWO,
                    go && ctrl_reg.chan == CH_SIX, 6'h00, 4'h0};
      4'h1:    word = {tx_cmd_reg[23:16], 12'h000};
      4'h2:    word = {tx_cmd_reg[15:0], 4'h0};
      4'h3:    word = {tx_front_reg[15:0], 4'h0};
      4'h4:    word = {tx_front_reg[31:16], 4'h0};
      4'h6:    word = {tx_clfe_reg[15:0], 4'h0};
      4'h7:    word = {tx_surr_reg[15:0], 4'h0};
      4'h8:    word = {tx_surr_reg[31:16], 4'h0};
      4'h9:    word = {tx_clfe_reg[31:16], 4'h0};
      default: word = 20'h00000;
    endcase
  end

  // Launch on bit clock rise; the codec captures on the fall.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_reg        <= SLOT_FINAL;
      sbit_reg        <= 5'h00;
      sh_reg          <= 20'h00000;
      ctrl_serial_out <= 1'b0;
      frame_sync      <= 1'b0;
    end else if (!active) begin
      slot_reg        <= SLOT_FINAL;
      sbit_reg        <= 5'h00;
      sh_reg          <= 20'h00000;
      ctrl_serial_out <= 1'b0;
      frame_sync      <= 1'b0;
    end else if (bclk_rise) begin
      if (sbit_reg == 5'h00) begin
        slot_reg        <= slot_next;
        sbit_reg        <= (slot_next == 4'h0) ? SLOT0_LAST : SLOTN_LAST;
        sh_reg          <= {word[18:0], 1'b0};
        ctrl_serial_out <= word[19];
        frame_sync      <= (slot_next == 4'h0);
      end else begin
        sbit_reg        <= sbit_reg - 5'h01;
        sh_reg          <= {sh_reg[18:0], 1'b0};
        ctrl_serial_out <= sh_reg[19];
      end
    end
  end

  // Snapshot the queued words at frame start so bus writes cannot tear a frame.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_cmd_reg    <= CMD_RST;
      tx_front_reg  <= 32'h00000000;
      tx_surr_reg   <= 32'h00000000;
      tx_clfe_reg   <= 32'h00000000;
    end else if (frame_start) begin
      tx_cmd_reg    <= cmd_pend_reg ? cmd_reg : CMD_RST;
      tx_front_reg  <= go ? front_reg : 32'h00000000;
      tx_surr_reg   <= go ? surr_reg : 32'h00000000;
      tx_clfe_reg   <= go ? clfe_reg : 32'h00000000;
    end
  end

  // ==========================================================================
  // Receivers, one per codec data line, sampled on bit clock fall.
  assign smp = bclk_fall && (state_reg == ST_RUN);

  aclc_rx_slots u_rx_first (
    .clk    (clk),
    .rst_b  (rst_b),
    .smp    (smp),
    .bit_in (pin_q[1]),
    .slot   (slot_reg),
    .last   (sbit_reg == 5'h00),
    .frame  (rx1),
    .done   (rx1_done)
  );

  aclc_rx_slots u_rx_second (
    .clk    (clk),
    .rst_b  (rst_b),
    .smp    (smp),
    .bit_in (pin_q[2]),
    .slot   (slot_reg),
    .last   (sbit_reg == 5'h00),
    .frame  (rx2),
    .done   (rx2_done)
  );

  // Replies and input samples come from the first codec's frame.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cstat_reg  <= 23'h000000;
      pcm_in_reg <= 32'h00000000;
    end else if (rx1_done) begin
      if (rx1.tag[TAG_S2]) begin
        cstat_reg <= {rx1.s1[18:12], rx1.s2[19:4]};
      end
      if (rx1.tag[TAG_S3]) begin
        pcm_in_reg <= {rx1.s4[19:4], rx1.s3[19:4]};
      end
    end
  end

  // ==========================================================================
  // Events. A rising data input while the link sleeps is a wake request.
  always_comb begin
    ev           = 4'h0;
    ev[EV_FRAME] = frame_start;
    ev[EV_CSTAT] = rx1_done && rx1.tag[TAG_S2];
    ev[EV_WAKE]  = !active && |(pin_q[2:1] & ~sdin_d_reg);
    ev[EV_TAKEN] = frame_start && go;
  end

  // Sticky status; a read clears only what it returned and a new set wins.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sts_reg <= 4'h0;
    end else if (rd_ack && avs_address == OFS_STAT) begin
      sts_reg <= (sts_reg & ~avs_readdata[3:0]) | ev;
    end else begin
      sts_reg <= sts_reg | ev;
    end
  end

  // Level interrupt while any unmasked status bit stands.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(sts_reg & mask_reg);
    end
  end

  // ==========================================================================
  // Bus handshake: a request waits one cycle, then is answered for one cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  assign rd_ack = avs_read && !avs_waitrequest;
  assign wr_ack = avs_write && !avs_waitrequest;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    case (avs_address)
      OFS_CTRL:  rd_mux = {28'h0000000, ctrl_reg};
      OFS_STAT:  rd_mux = {28'h0000000, sts_reg};
      OFS_MASK:  rd_mux = {28'h0000000, mask_reg};
      OFS_CMD:   rd_mux = {cmd_pend_reg, 7'h00, cmd_reg};
      OFS_CSTAT: rd_mux = {9'h000, cstat_reg};
      OFS_FRONT: rd_mux = front_reg;
      OFS_SURR:  rd_mux = surr_reg;
      OFS_CLFE:  rd_mux = clfe_reg;
      OFS_LINK:  rd_mux = {24'h000000, qv_reg, pin_q[3], pin_q[2:1],
                           rx2.tag[TAG_VALID], rx1.tag[TAG_VALID]};
      OFS_PCMIN: rd_mux = pcm_in_reg;
      default:   rd_mux = 32'h00000000;
    endcase
  end

  // Read data is caught while waitrequest is high and stands at the answer.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  assign wm = aclc_merge(rd_mux, avs_writedata, avs_byteenable);

  // Control and mask registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= aclc_ctrl_type'(CTRL_RST);
      mask_reg <= MASK_RST;
    end else if (wr_ack) begin
      if (avs_address == OFS_CTRL) begin
        ctrl_reg <= aclc_ctrl_type'(wm[3:0]);
      end
      if (avs_address == OFS_MASK) begin
        mask_reg <= wm[3:0];
      end
    end
  end

  // Command queue: a write arms it, the frame that carries it disarms it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_reg      <= CMD_RST;
      cmd_pend_reg <= 1'b0;
    end else if (wr_ack && avs_address == OFS_CMD) begin
      cmd_reg      <= wm[23:0];
      cmd_pend_reg <= 1'b1;
    end else if (frame_start) begin
      cmd_pend_reg <= 1'b0;
    end
  end

  // Sample queues; a write in the frame-start cycle keeps its flag set.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      front_reg <= 32'h00000000;
      surr_reg  <= 32'h00000000;
      clfe_reg  <= 32'h00000000;
      qv_reg    <= 3'h0;
    end else begin
      if (frame_start && go) begin
        qv_reg <= 3'h0;
      end
      if (wr_ack && avs_address == OFS_FRONT) begin
        front_reg <= wm;
        qv_reg[0] <= 1'b1;
      end
      if (wr_ack && avs_address == OFS_SURR) begin
        surr_reg  <= wm;
        qv_reg[1] <= 1'b1;
      end
      if (wr_ack && avs_address == OFS_CLFE) begin
        clfe_reg  <= wm;
        qv_reg[2] <= 1'b1;
      end
    end
  end

endmodule : aclc_link_ctrl
`default_nettype wire

// ==== verilog/aclc_pkg.sv ====
// Shared constants, types and helpers for the serial audio link controller.
package aclc_pkg;

  // ==========================================================================
  // Register byte offsets on the bus.
  localparam logic [5:0] OFS_CTRL  = 6'h00; // Link control.
  localparam logic [5:0] OFS_STAT  = 6'h04; // Sticky events, cleared by read.
  localparam logic [5:0] OFS_MASK  = 6'h08; // Interrupt mask.
  localparam logic [5:0] OFS_CMD   = 6'h0c; // Codec register command.
  localparam logic [5:0] OFS_CSTAT = 6'h10; // Last codec status reply.
  localparam logic [5:0] OFS_FRONT = 6'h14; // Front left/right sample.
  localparam logic [5:0] OFS_SURR  = 6'h18; // Surround left/right sample.
  localparam logic [5:0] OFS_CLFE  = 6'h1c; // Centre/low-frequency sample.
  localparam logic [5:0] OFS_LINK  = 6'h20; // Live link state.
  localparam logic [5:0] OFS_PCMIN = 6'h24; // Last received input sample.

  // ==========================================================================
  // Reset values.
  localparam logic [3:0]  CTRL_RST = 4'h0;
  localparam logic [3:0]  MASK_RST = 4'h0;
  localparam logic [23:0] CMD_RST  = 24'h000000;

  // ==========================================================================
  // Frame geometry: slot 0 has 16 bits, slots 1 to 12 have 20 bits each.
  localparam logic [4:0] SLOT0_LAST = 5'h0f;
  localparam logic [4:0] SLOTN_LAST = 5'h13;
  localparam logic [3:0] SLOT_FINAL = 4'hc;

  // Tag bit positions in slot 0.
  localparam int TAG_VALID = 15;
  localparam int TAG_S2    = 13;
  localparam int TAG_S3    = 12;

  // Slot request bits in incoming slot 1; a low bit asks for data.
  localparam int REQ_S3 = 11;
  localparam int REQ_S6 = 8;
  localparam int REQ_S7 = 7;
  localparam int REQ_S8 = 6;
  localparam int REQ_S9 = 5;

  // Event bits of the status and mask registers.
  localparam int EV_FRAME = 0;
  localparam int EV_CSTAT = 1;
  localparam int EV_WAKE  = 2;
  localparam int EV_TAKEN = 3;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {CH_TWO, CH_FOUR, CH_SIX, CH_RSVD} aclc_chan_type;

  typedef struct packed {
    aclc_chan_type chan;     // Output channel count.
    logic          link_run; // Releases the link reset.
    logic          link_off; // Link shut-off control.
  } aclc_ctrl_type;

  typedef struct packed {
    logic [15:0] tag;
    logic [19:0] s1;
    logic [19:0] s2;
    logic [19:0] s3;
    logic [19:0] s4;
  } aclc_frame_type;

  // Byte-enable merge of a bus write into a stored word.
  function automatic logic [31:0] aclc_merge(input logic [31:0] old,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return res;
  endfunction : aclc_merge

endpackage : aclc_pkg

// ==== verilog/aclc_pin_sync.sv ====
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module aclc_pin_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Raw and synchronised levels.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg; // First stage, read only by the second.

  // ==========================================================================
  // Both stages; only the second is visible outside.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : aclc_pin_sync
`default_nettype wire

// ==== verilog/aclc_rx_slots.sv ====
// Deserialiser for one codec's incoming serial data line.
`timescale 1ns/1ns
`default_nettype none
module aclc_rx_slots
  import aclc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Bit timing from the frame counter.
  input  wire logic       smp,
  input  wire logic       bit_in,
  input  wire logic [3:0] slot,
  input  wire logic       last,
  // Captured frame and its end pulse.
  output aclc_frame_type  frame,
  output logic            done
);

  logic [19:0] sh_reg;  // Bits of the slot in progress.
  logic [19:0] sh_next; // Shifter with the newest bit added.

  assign sh_next = {sh_reg[18:0], bit_in};

  // ==========================================================================
  // Shift on each sample strobe and file the word at the slot's last bit.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_reg <= 20'h00000;
      frame  <= '0;
    end else if (smp) begin
      sh_reg <= last ? 20'h00000 : sh_next;
      if (last) begin
        case (slot)
          4'h0:    frame.tag <= sh_next[15:0];
          4'h1:    frame.s1  <= sh_next;
          4'h2:    frame.s2  <= sh_next;
          4'h3:    frame.s3  <= sh_next;
          4'h4:    frame.s4  <= sh_next;
          default: frame.tag <= frame.tag; // Other slots are not kept.
        endcase
      end
    end
  end

  // ==========================================================================
  // One-cycle pulse once the last bit of slot 12 has been sampled.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done <= 1'b0;
    end else begin
      done <= smp && last && (slot == SLOT_FINAL);
    end
  end

endmodule : aclc_rx_slots
`default_nettype wire

// ==== tb/aclc_link_ctrl_monitor.sv ====
// Checker of bus handshake and link framing for the link controller.
`timescale 1ns/1ns
`default_nettype none
module aclc_link_ctrl_monitor (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Bus slave.
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Link pins.
  input  wire logic        bit_clk,
  input  wire logic        frame_sync,
  input  wire logic        ctrl_serial_out,
  input  wire logic        ctrl_serial_out_oe,
  input  wire logic        link_reset_n,
  input  wire logic        pull_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Bit clock rises since frame start; armed once a frame has begun.
  logic       bck_reg;
  logic [8:0] bits_reg;
  logic       arm_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bck_reg  <= 1'b0;
      bits_reg <= 9'h000;
      arm_reg  <= 1'b0;
    end else begin
      bck_reg <= bit_clk;
      if ($rose(frame_sync)) begin
        bits_reg <= 9'h000;
        arm_reg  <= link_reset_n;
      end else if (bit_clk && !bck_reg) begin
        bits_reg <= bits_reg + 9'h001;
      end
    end
  end
  // ==========================================================================
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle after request");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  a_read_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
    else $error("read data changed outside a read");
  a_pull_drive: assert property (pull_enable != ctrl_serial_out_oe)
    else $error("pull and drive not exclusive");
  a_off_idle: assert property (pull_enable && $past(pull_enable, 4) |-> !frame_sync && !ctrl_serial_out)
    else $error("link active while shut off");
  a_reset_idle: assert property ((!link_reset_n)[*3] |-> !frame_sync)
    else $error("frame while link in reset");
  a_sync_len: assert property ($fell(frame_sync) |-> bits_reg == 9'h010)
    else $error("sync not sixteen bits");
  a_frame_len: assert property ($rose(frame_sync) && arm_reg |-> bits_reg == 9'h100)
    else $error("frame not 256 bits");
endmodule : aclc_link_ctrl_monitor
bind aclc_link_ctrl aclc_link_ctrl_monitor i_aclc_link_ctrl_monitor (
  .clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bit_clk(bit_clk),
  .frame_sync(frame_sync), .ctrl_serial_out(ctrl_serial_out),
  .ctrl_serial_out_oe(ctrl_serial_out_oe), .link_reset_n(link_reset_n),
  .pull_enable(pull_enable));
`default_nettype wire

// ==== tb/aclc_codec_model.sv ====
// Behavioural codec on one serial input line of the link.
`timescale 1ns/1ns
`default_nettype none
module aclc_codec_model (
  // Link pins: bit clock from the bench, reset and sync from the controller.
  input  wire logic bit_clk,
  input  wire logic link_reset_n,
  input  wire logic frame_sync,
  // Scenario controls.
  input  wire logic req,
  input  wire logic wake,
  // Data to the controller.
  output logic      sdata
);
  logic [7:0]  pos = 8'h00; // Bit position in the frame.
  logic [1:0]  sy  = 2'b00; // Sync seen at falling edges.
  logic [35:0] hdr;         // Tag and slot 1, first bit on top.
  // Sync is seen on a fall, so the following rise carries bit 1.
  always @(negedge bit_clk) sy <= {sy[0], frame_sync};
  always @(posedge bit_clk) pos <= (sy == 2'b01) ? 8'h01 : pos + 8'h01;
  // A low bit in slot 1 asks for data.
  assign hdr = {16'hc000, req ? 20'h00000 : 20'h00ffc};
  // In reset the line shows the wake level, idle low like its pull-down.
  always_comb begin
    if (!link_reset_n) sdata = wake;
    else sdata = (pos < 8'h24) ? hdr[8'h23 - pos] : 1'b0;
  end
endmodule : aclc_codec_model
`default_nettype wire

// ==== tb/aclc_link_ctrl_tb.sv ====
// Self-checking bench for the serial audio link controller.
`timescale 1ns/1ns
`default_nettype none
module aclc_link_ctrl_tb;
  import aclc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0, bck = 1'b0;
  logic req2 = 1'b0, wake = 1'b0, bcen_n = 1'b0, s1, s2, wt, irq, fs, so, oe, lrn, pe;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [7:0]  lf = 8'h4e;
  int          err_total = 0;
  int          checked = 0;
  always #5 clk = ~clk;
  // Link clock of the primary codec, still while the link is in reset.
  initial begin #3; forever #40 bck = lrn ? ~bck : 1'b0; end
  aclc_link_ctrl i_aclc_link_ctrl (.clk(clk), .rst_b(rst_b), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdat), .avs_waitrequest(wt), .irq(irq), .bit_clk(bck),
    .serial_in_first(s1), .serial_in_second(s2), .frame_sync(fs), .ctrl_serial_out(so),
    .ctrl_serial_out_oe(oe), .link_reset_n(lrn), .pull_enable(pe),
    .board_codec_enable_n(bcen_n));
  aclc_codec_model i_aclc_codec_model_a (.bit_clk(bck), .link_reset_n(lrn),
    .frame_sync(fs), .req(1'b1), .wake(1'b0), .sdata(s1));
  aclc_codec_model i_aclc_codec_model_b (.bit_clk(bck), .link_reset_n(lrn & ~bcen_n),
    .frame_sync(fs), .req(req2), .wake(wake), .sdata(s2));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a; wr <= w; rd <= !w; wd <= d;
    do begin @(posedge clk); n++; end while (wt !== 1'b0 && n < 20);
    chk("waitrequest", 32'(wt), 32'h0);
    q = rdat;
    rd <= 1'b0; wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  initial begin #700000; err_total++; summarize; end
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("reset pins", 32'({wt, irq, lrn, oe, pe, fs}), 32'h24);
    bus(1'b0, OFS_CTRL, 32'h0); chk("ctrl", q, 32'(CTRL_RST));
    bus(1'b0, OFS_MASK, 32'h0); chk("mask", q, 32'(MASK_RST));
    bus(1'b0, 6'h3c, 32'h0); chk("unmapped", q, 32'h0);
    bcen_n <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b0, OFS_LINK, 32'h0); chk("strap", 32'(q[4]), 32'h1);
    chk("pins off", 32'({pe, oe, so}), 32'h4);
    $display("test shut-off done");
    bcen_n <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0); bus(1'b1, OFS_MASK, 32'h4); bus(1'b0, OFS_STAT, 32'h0);
    wake <= 1'b1; repeat (6) @(posedge clk); chk("irq wake", 32'(irq), 32'h1);
    bus(1'b0, OFS_STAT, 32'h0); chk("wake", 32'(q[EV_WAKE]), 32'h1);
    wake <= 1'b0; repeat (3) @(posedge clk); chk("irq clear", 32'(irq), 32'h0);
    bus(1'b1, OFS_MASK, 32'h0); wake <= 1'b1; repeat (6) @(posedge clk);
    chk("irq masked", 32'(irq), 32'h0); wake <= 1'b0;
    $display("test wake done");
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 2; r++) begin
        req2 <= r[0];
        bus(1'b1, OFS_CTRL, {28'h0, 2'(m), 2'b10});
        repeat (2048) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0);
        for (int k = 0; k < 3; k++) begin
          lf = lfsr(lf);
          bus(1'b1, OFS_FRONT + 6'(4 * k), {4{lf}});
        end
        repeat (6144) @(posedge clk);
        bus(1'b0, OFS_STAT, 32'h0);
        chk("taken", 32'(q[EV_TAKEN]), 32'(m == 0 || r == 1));
        chk("frame", 32'(q[EV_FRAME]), 32'h1);
        chk("link reset", 32'(lrn), 32'h1);
        $display("test channels %0d request %0d done", m, r);
      end
    end
    summarize;
  end
endmodule : aclc_link_ctrl_tb
`default_nettype wire
